// ===== design/sl_pkg.sv
package sl_pkg;

	// link geometry
	localparam int NUM_LANES = 4;
	localparam int NUM_SLOTS = 7;
	localparam int WORD_W = 28;
	localparam int SLOT_W = 3;
	localparam logic [SLOT_W-1:0] LAST_SLOT = 3'h6;
	// forwarded clock stays high for the first slots of a frame
	localparam logic [SLOT_W-1:0] FCLK_HIGH_SLOTS = 3'h4;
	// receiver word clock high time in cycles
	localparam logic [2:0] WCLK_HIGH_CYCLES = 3'h4;

	// pll lock interval
	localparam int CLK_FREQ_HZ = 50_000_000;
	localparam int LOCK_TIME_MS = 10;
	localparam int LOCK_CYCLES_DFLT = LOCK_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int LOCK_CNT_W = 20;

	// reset values
	localparam logic [WORD_W-1:0] WORD_RST = 28'h0000000;
	localparam logic [NUM_LANES-1:0] LANES_RST = 4'h0;
	localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_RST = 20'h00000;

	// differential data lanes with a shared enable
	typedef struct packed {
		logic [NUM_LANES-1:0] p;
		logic [NUM_LANES-1:0] n;
		logic oe;
	} sl_lane_pair_t;

	// differential clock pair with enable
	typedef struct packed {
		logic p;
		logic n;
		logic oe;
	} sl_clk_pair_t;

	// differential inputs
	typedef struct packed {
		logic [NUM_LANES-1:0] p;
		logic [NUM_LANES-1:0] n;
	} sl_lane_in_t;

	typedef struct packed {
		logic p;
		logic n;
	} sl_clk_in_t;

	// whole block state
	typedef struct packed {
		logic tx_clk_s1;
		logic tx_clk_s2;
		logic tx_clk_s3;
		logic [WORD_W-1:0] tx_data_s1;
		logic [WORD_W-1:0] tx_data_s2;
		logic tx_pd_s1;
		logic tx_pd_s2;
		logic [LOCK_CNT_W-1:0] tx_lock_cnt;
		logic tx_locked;
		logic [WORD_W-1:0] tx_word;
		logic [SLOT_W-1:0] tx_slot;
		logic tx_busy;
		logic [NUM_LANES-1:0] tx_lane;
		logic tx_fclk;
		logic rx_clk_s1;
		logic rx_clk_s2;
		logic rx_clk_s3;
		logic [NUM_LANES-1:0] rx_lane_s1;
		logic [NUM_LANES-1:0] rx_lane_s2;
		logic rx_pd_s1;
		logic rx_pd_s2;
		logic [LOCK_CNT_W-1:0] rx_lock_cnt;
		logic rx_locked;
		logic [WORD_W-1:0] rx_shift;
		logic [SLOT_W-1:0] rx_slot;
		logic rx_busy;
		logic [WORD_W-1:0] rx_data;
		logic [2:0] rx_wcnt;
		logic rx_wclk;
	} sl_state_t;

endpackage

// ===== design/sl_link_top.sv
// Contract
// (R01) The transmitter takes the whole parallel word on each rising edge of its word clock.
// (R02) The transmitter sends the word over four differential lanes with true and complement.
// (R03) The transmitter forwards its frame clock on a dedicated differential pair.
// (R04) A low transmit power-down input floats every serial data and clock output.
// (R05) The receiver rebuilds the parallel word from its four differential lanes.
// (R06) The receiver uses the forwarded clock as the timing reference for its lanes.
// (R07) The receiver raises its word clock only while the rebuilt word is steady.
// (R08) A low receive power-down input forces every parallel output low.
// (R09) Each lane carries seven slots per forwarded clock period.
// (R10) Outputs stay quiet until the lock interval has run after power-down is released.
// (R11) When the forwarded clock stops, the parallel outputs keep their last values.
// (R12) Bit lane*7+slot travels in that lane and slot on both ends, slot 0 first.
`timescale 1ns/1ps

module sl_link_top
	import sl_pkg::*;
#(
	parameter int LOCK_CYCLES = LOCK_CYCLES_DFLT
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WORD_W-1:0] tx_parallel_data_in,
	input wire logic tx_word_clock_in,
	input wire logic tx_power_down_n,
	output sl_lane_pair_t tx_serial_lane_out,
	output sl_clk_pair_t tx_forwarded_clock_out,
	input wire sl_lane_in_t rx_serial_lane_in,
	input wire sl_clk_in_t rx_forwarded_clock_in,
	input wire logic rx_power_down_n,
	output logic [WORD_W-1:0] rx_parallel_data_out,
	output logic rx_word_clock_out
);

	localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCK_CYCLES - 1);

	sl_state_t s_q;
	sl_state_t s_d;
	logic tx_edge;
	logic tx_start;
	logic rx_edge;
	logic rx_start;
	logic rx_done;
	logic [NUM_LANES-1:0] rx_lane_bits;
	logic rx_clk_bit;
	logic [WORD_W-1:0] rx_word_next;

	// differential receivers
	assign rx_lane_bits = rx_serial_lane_in.p & ~rx_serial_lane_in.n;
	assign rx_clk_bit = rx_forwarded_clock_in.p & ~rx_forwarded_clock_in.n;

	// edge detection on synchronised clocks
	assign tx_edge = s_q.tx_clk_s2 & ~s_q.tx_clk_s3;
	assign tx_start = tx_edge & s_q.tx_locked & s_q.tx_pd_s2;
	assign rx_edge = s_q.rx_clk_s2 & ~s_q.rx_clk_s3; // [R06]
	assign rx_start = rx_edge & s_q.rx_locked & s_q.rx_pd_s2;
	assign rx_done = s_q.rx_busy & (s_q.rx_slot == LAST_SLOT) & ~rx_start;

	// receive slot deposit, one bit per lane
	always_comb
	begin
		rx_word_next = s_q.rx_shift;
		for (int l = 0; l < NUM_LANES; l++)
		begin
			if (rx_start)
				rx_word_next[l*NUM_SLOTS] = s_q.rx_lane_s2[l]; // [R12]
			else if (s_q.rx_busy)
				rx_word_next[l*NUM_SLOTS + int'(s_q.rx_slot)] = s_q.rx_lane_s2[l]; // [R05] [R12]
		end
	end

	// next state
	always_comb
	begin
		s_d = s_q; // rebuilt word holds unless a frame completes or receive power-down clears it [R11]
		// pin synchronisers
		s_d.tx_clk_s1 = tx_word_clock_in;
		s_d.tx_clk_s2 = s_q.tx_clk_s1;
		s_d.tx_clk_s3 = s_q.tx_clk_s2;
		s_d.tx_data_s1 = tx_parallel_data_in;
		s_d.tx_data_s2 = s_q.tx_data_s1;
		s_d.tx_pd_s1 = tx_power_down_n;
		s_d.tx_pd_s2 = s_q.tx_pd_s1;
		s_d.rx_clk_s1 = rx_clk_bit;
		s_d.rx_clk_s2 = s_q.rx_clk_s1;
		s_d.rx_clk_s3 = s_q.rx_clk_s2;
		s_d.rx_lane_s1 = rx_lane_bits;
		s_d.rx_lane_s2 = s_q.rx_lane_s1;
		s_d.rx_pd_s1 = rx_power_down_n;
		s_d.rx_pd_s2 = s_q.rx_pd_s1;

		// lock timers, restarted by power-down
		if (!s_q.tx_pd_s2)
		begin
			s_d.tx_lock_cnt = LOCK_CNT_RST;
			s_d.tx_locked = 1'b0;
		end
		else if (!s_q.tx_locked)
		begin
			s_d.tx_lock_cnt = s_q.tx_lock_cnt + 1'b1;
			s_d.tx_locked = (s_q.tx_lock_cnt == LOCK_LAST); // [R10]
		end
		if (!s_q.rx_pd_s2)
		begin
			s_d.rx_lock_cnt = LOCK_CNT_RST;
			s_d.rx_locked = 1'b0;
		end
		else if (!s_q.rx_locked)
		begin
			s_d.rx_lock_cnt = s_q.rx_lock_cnt + 1'b1;
			s_d.rx_locked = (s_q.rx_lock_cnt == LOCK_LAST); // [R10]
		end

		// transmit framing: slot 0 goes out with the forwarded clock rise
		if (tx_start)
		begin
			s_d.tx_word = s_q.tx_data_s2; // [R01]
			s_d.tx_slot = 3'h1;
			s_d.tx_busy = 1'b1;
			s_d.tx_fclk = 1'b1; // [R03]
			for (int l = 0; l < NUM_LANES; l++)
				s_d.tx_lane[l] = s_q.tx_data_s2[l*NUM_SLOTS]; // [R02] [R12]
		end
		else if (s_q.tx_busy && s_q.tx_locked && s_q.tx_pd_s2)
		begin
			s_d.tx_slot = s_q.tx_slot + 1'b1;
			s_d.tx_busy = (s_q.tx_slot != LAST_SLOT); // [R09]
			s_d.tx_fclk = (s_q.tx_slot < FCLK_HIGH_SLOTS); // [R03]
			for (int l = 0; l < NUM_LANES; l++)
				s_d.tx_lane[l] = s_q.tx_word[l*NUM_SLOTS + int'(s_q.tx_slot)]; // [R02] [R12]
		end
		else
		begin
			s_d.tx_busy = 1'b0;
			s_d.tx_fclk = 1'b0;
			s_d.tx_lane = LANES_RST; // [R10]
		end

		// receive framing and word strobe
		s_d.rx_shift = rx_word_next;
		if (rx_start)
		begin
			s_d.rx_slot = 3'h1;
			s_d.rx_busy = 1'b1;
		end
		else if (s_q.rx_busy)
		begin
			s_d.rx_slot = s_q.rx_slot + 1'b1;
			s_d.rx_busy = !rx_done; // [R09]
		end
		if (!s_q.rx_pd_s2)
		begin
			s_d.rx_busy = 1'b0;
			s_d.rx_data = WORD_RST; // [R08]
			s_d.rx_wcnt = 3'h0;
		end
		else if (rx_done)
		begin
			s_d.rx_data = rx_word_next; // [R05]
			s_d.rx_wcnt = WCLK_HIGH_CYCLES;
		end
		else if (s_q.rx_wcnt != 3'h0)
			s_d.rx_wcnt = s_q.rx_wcnt - 1'b1;
		// strobe rises a cycle after the word changes
		s_d.rx_wclk = (s_q.rx_wcnt != 3'h0) & s_q.rx_pd_s2; // [R07]
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// pin drivers
	always_comb
	begin
		tx_serial_lane_out.oe = s_q.tx_pd_s2; // [R04]
		tx_serial_lane_out.p = s_q.tx_lane;
		tx_serial_lane_out.n = ~s_q.tx_lane;
		tx_forwarded_clock_out.oe = s_q.tx_pd_s2; // [R04]
		tx_forwarded_clock_out.p = s_q.tx_fclk;
		tx_forwarded_clock_out.n = ~s_q.tx_fclk;
	end
	assign rx_parallel_data_out = s_q.rx_data;
	assign rx_word_clock_out = s_q.rx_wclk;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence tx_fclk_frame_s;
		s_q.tx_fclk [*4] ##1 !s_q.tx_fclk [*3];
	endsequence

	sequence rx_strobe_s;
		!rx_word_clock_out ##1 rx_word_clock_out [*4] ##1 !rx_word_clock_out;
	endsequence

	tx_powerdown_hiz_a: assert property (!s_q.tx_pd_s1 |=> // [R04]
		!tx_serial_lane_out.oe && !tx_forwarded_clock_out.oe)
		else $error("tx outputs driven while powered down");

	rx_powerdown_zero_a: assert property (!s_q.rx_pd_s2 |=> // [R08]
		rx_parallel_data_out == WORD_RST)
		else $error("rx data not low in power down");

	tx_word_capture_a: assert property (tx_start |=> // [R01]
		s_q.tx_word == $past(s_q.tx_data_s2))
		else $error("tx word not captured at clock edge");

	tx_frame_clock_a: assert property (tx_start |=> tx_fclk_frame_s) // [R03]
		else $error("forwarded clock frame shape wrong");

	tx_lane_map_a: assert property (tx_start |=> // [R12]
		s_q.tx_lane[0] == $past(s_q.tx_data_s2[0])
		&& s_q.tx_lane[3] == $past(s_q.tx_data_s2[21])
		##6 s_q.tx_lane[0] == $past(s_q.tx_data_s2[6], 7))
		else $error("tx lane slot mapping wrong");

	tx_lock_quiet_a: assert property (!s_q.tx_locked |=> // [R10]
		!s_q.tx_fclk && s_q.tx_lane == LANES_RST)
		else $error("tx toggles before lock");

	rx_frame_len_a: assert property (rx_start |-> ##6 rx_done) // [R09]
		else $error("rx frame not seven slots");

	rx_strobe_data_a: assert property (rx_done && s_q.rx_pd_s2 |=> rx_strobe_s) // [R07]
		else $error("rx word clock timing wrong");

	rx_strobe_stable_a: assert property ($rose(rx_word_clock_out) |-> // [R07]
		$stable(rx_parallel_data_out))
		else $error("rx data moves at strobe edge");

	rx_hold_idle_a: assert property (!s_q.rx_busy && !rx_start && s_q.rx_pd_s2 // [R11]
		&& s_q.rx_pd_s1 |=> $stable(rx_parallel_data_out))
		else $error("rx data changed without clock");

	rx_lock_quiet_a: assert property (!s_q.rx_locked |=> !s_q.rx_busy) // [R10]
		else $error("rx frames before lock");

endmodule

// ===== tb/sl_cable_model.sv
`timescale 1ns/1ps

module sl_cable_model
	import sl_pkg::*;
(
	input wire logic clk,
	input wire sl_lane_pair_t lanes_in,
	input wire sl_clk_pair_t fclk_in,
	output sl_lane_in_t lanes_out,
	output sl_clk_in_t fclk_out
);
	logic float_q = 1'b0;

	// a floated pair wanders, so never reads as the last driven value
	always @(posedge clk)
		float_q <= ~float_q;

	// driven pairs pass straight through, lane order untouched
	always_comb
	begin
		lanes_out.p = lanes_in.oe ? lanes_in.p : {NUM_LANES{float_q}};
		lanes_out.n = lanes_in.oe ? lanes_in.n : {NUM_LANES{float_q}};
		fclk_out.p = fclk_in.oe ? fclk_in.p : float_q;
		fclk_out.n = fclk_in.oe ? fclk_in.n : float_q;
	end
endmodule

// ===== tb/sl_link_top_tb.sv
`timescale 1ns/1ps

module sl_link_top_tb;
	import sl_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [WORD_W-1:0] din = '0;
	logic wclk_in = 1'b0;
	logic tx_pd_n = 1'b1;
	logic rx_pd_n = 1'b1;
	logic run = 1'b0;
	logic push_en = 1'b0;
	logic wclk_seen = 1'b0;
	logic fclk_seen = 1'b0;
	logic [2:0] phase = 3'h0;
	logic [15:0] pushes = 16'h0000;
	logic [15:0] fclk_rises = 16'h0000;
	logic [31:0] seed = 32'h39A69D62;
	logic [WORD_W-1:0] q[$];
	logic [WORD_W-1:0] last = '0;
	int num_errors = 0;
	int compares = 0;
	sl_lane_pair_t tx_lanes;
	sl_clk_pair_t tx_fclk;
	sl_lane_in_t rx_lanes;
	sl_clk_in_t rx_fclk;
	logic [WORD_W-1:0] rx_data;
	logic rx_wclk;

	always #10 clk = ~clk;

	sl_link_top #(.LOCK_CYCLES(20)) DUT (.clk(clk), .rst_n(rst_n),
		.tx_parallel_data_in(din), .tx_word_clock_in(wclk_in), .tx_power_down_n(tx_pd_n),
		.tx_serial_lane_out(tx_lanes), .tx_forwarded_clock_out(tx_fclk),
		.rx_serial_lane_in(rx_lanes), .rx_forwarded_clock_in(rx_fclk),
		.rx_power_down_n(rx_pd_n), .rx_parallel_data_out(rx_data), .rx_word_clock_out(rx_wclk));

	sl_cable_model cable (.clk(clk), .lanes_in(tx_lanes), .fclk_in(tx_fclk),
		.lanes_out(rx_lanes), .fclk_out(rx_fclk));

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic check(input string what, input logic [WORD_W-1:0] exp,
		input logic [WORD_W-1:0] got);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic test_done;
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// word clock of eight cycles, new random word while it is low
	always @(negedge clk)
	begin
		phase <= run ? phase + 3'h1 : 3'h0;
		if (run && phase == 3'h3)
		begin
			wclk_in <= 1'b1;
			if (push_en)
			begin
				q.push_back(din);
				pushes <= pushes + 16'h0001;
			end
		end
		if (!run || phase == 3'h7)
		begin
			wclk_in <= 1'b0;
			seed = xorshift(seed);
			din <= seed[WORD_W-1:0];
		end
	end

	// pair polarity, frame count and rebuilt words against the model
	always @(negedge clk)
	begin
		wclk_seen <= rx_wclk;
		fclk_seen <= tx_fclk.p;
		if (tx_fclk.p === 1'b1 && fclk_seen === 1'b0)
			fclk_rises <= fclk_rises + 16'h0001;
		if (tx_lanes.oe === 1'b1)
			check("pair complement", {23'h0, tx_fclk.n, tx_lanes.n},
				{23'h0, ~tx_fclk.p, ~tx_lanes.p});
		if (rx_wclk === 1'b1 && wclk_seen === 1'b0)
		begin
			last = (q.size() > 0) ? q.pop_front() : 'x;
			check("rebuilt word", last, rx_data);
		end
	end

	// main sequence
	initial
	begin
		repeat (6) @(negedge clk);
		rst_n <= 1'b1;
		run <= 1'b1;
		repeat (14) @(negedge clk);
		run <= 1'b0;
		repeat (30) @(negedge clk);
		check("early frames", '0, {12'h0, fclk_rises});
		push_en <= 1'b1;
		run <= 1'b1;
		repeat (320) @(negedge clk);
		run <= 1'b0;
		repeat (40) @(negedge clk);
		check("held word", last, rx_data);
		check("frames sent", {12'h0, pushes}, {12'h0, fclk_rises});
		rx_pd_n <= 1'b0;
		tx_pd_n <= 1'b0;
		repeat (6) @(negedge clk);
		check("powered-down word", '0, rx_data);
		check("output enables", '0, {26'h0, tx_lanes.oe, tx_fclk.oe});
		// release power down, word clocks during relock must be ignored
		rx_pd_n <= 1'b1;
		tx_pd_n <= 1'b1;
		push_en <= 1'b0;
		run <= 1'b1;
		repeat (14) @(negedge clk);
		run <= 1'b0;
		repeat (30) @(negedge clk);
		check("relock frames", {12'h0, pushes}, {12'h0, fclk_rises});
		// traffic again once relocked
		push_en <= 1'b1;
		run <= 1'b1;
		repeat (80) @(negedge clk);
		run <= 1'b0;
		repeat (40) @(negedge clk);
		check("relocked word", last, rx_data);
		check("frames resent", {12'h0, pushes}, {12'h0, fclk_rises});
		test_done();
	end

	// watchdog
	initial
	begin
		#50000;
		num_errors++;
		test_done();
	end
endmodule
